// ---- npr_pkg.sv ----
/*
  Shared constants and types for the next page register bank.
  Assumes a 32-bit AXI4-Lite bus and a same-clock arbitration engine.
*/
package npr_pkg;

  // One link code word of the next page exchange
  typedef struct packed {
    logic more_pages_flag;
    logic ack;
    logic message_page_flag;
    logic comply_acknowledge;
    logic alternation_bit;
    logic [10:0] code;
  } npr_lcw_s;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_NEXT_PAGE_OUT = 8'h07;
  localparam logic [7:0] IDX_NEXT_PAGE_IN = 8'h08;
  localparam logic [7:0] IDX_PAGE_STATUS = 8'h10;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h11;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h12;

  // Bit positions inside a link code word
  localparam int BIT_MORE = 15;
  localparam int BIT_ACK = 14;
  localparam int BIT_MSG = 13;
  localparam int BIT_COMPLY = 12;
  localparam int BIT_ALT = 11;

  // Reset values: message page set, code holds the null message
  localparam logic [10:0] CODE_NULL_MSG = 11'h001;
  localparam logic [15:0] NP_RESET = 16'h2001;
  // Bits that software may write in the outgoing page
  localparam logic [15:0] NP_OUT_WMASK = 16'hb7ff;

  // Status and interrupt layout
  localparam int EVT_RX_PAGE = 0;
  localparam int EVT_TX_PAGE = 1;
  localparam int EVT_N = 2;
  localparam logic [EVT_N-1:0] IRQ_MASK_RESET = 2'h0;

  // AXI answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- npr_sticky.sv ----
/*
  One sticky event bit: set by hardware, cleared by software.
  Assumes set and clear are pulses on the same clock.
*/
`timescale 1ns/10ps
module npr_sticky (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic q_o
);

  // A set in the clearing cycle wins so no event is lost
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q_o <= 1'b0;
    end else begin
      q_o <= set_i | (q_o & ~clr_i);
    end
  end

endmodule

// ---- npr_chan_hold.sv ----
/*
  Holding stage for one AXI request channel: takes one item, keeps it
  until the consumer pulses take_i. Ready comes from a flip-flop.
*/
`timescale 1ns/10ps
module npr_chan_hold #(
  parameter int W = 32
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic valid_i,
  input wire logic [W-1:0] data_i,
  input wire logic take_i,
  output logic ready_o,
  output logic full_o,
  output logic [W-1:0] data_o
);

  logic full_next;

  // Full once the handshake lands, empty once consumed
  always_comb begin
    full_next = full_o;
    if (valid_i && ready_o) begin
      full_next = 1'b1;
    end else if (take_i) begin
      full_next = 1'b0;
    end
  end

  // Ready is the registered inverse of the next fill state
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      full_o <= 1'b0;
      ready_o <= 1'b0;
      data_o <= '0;
    end else begin
      full_o <= full_next;
      ready_o <= ~full_next;
      if (valid_i && ready_o) begin
        data_o <= data_i;
      end
    end
  end

endmodule

// ---- npr_top.sv ----
/*
  Next page register bank of an auto-negotiation engine: the page the
  local end sends, the page captured from the partner, a page received
  flag, and an interrupt bank, all on an AXI4-Lite slave.
  Assumes the arbitration engine runs on CLK_SYS_I and gives pulses
  for each accepted received word and each word sent.
*/
// Decided for this implementation: register access over AXI4-Lite.
// Overview of operation
// - Outgoing bit 15 writable: more pages wanted
// - Outgoing bit 14 read-only local acknowledge
// - Outgoing bit 13 writable, resets one, message
// - Outgoing bit 12 writable comply, resets zero
// - Outgoing bit 11 inverts previous exchanged toggle
// - Code field meaning follows message page flag
// - Code field resets to null message
// - Incoming bit 15 shows partner wants more
// - Incoming bit 14 shows partner acknowledge
// - Incoming bit 13 resets one, message page
// - Incoming bit 12 shows partner comply acknowledge
// - Partner next pages live at index eight
// - Page received flag sets, clears on read
`timescale 1ns/10ps
module npr_top (
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  // AXI4-Lite slave
  input wire logic [31:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [31:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // Arbitration engine side
  input wire logic LCW_RX_VALID_I,
  input wire npr_pkg::npr_lcw_s LCW_RX_WORD_I,
  input wire logic LCW_TX_SENT_I,
  input wire logic LOCAL_ACK_I,
  output npr_pkg::npr_lcw_s NP_TX_WORD_O,
  output logic PAGE_RX_FLAG_O,
  output logic IRQ_O
);

  npr_pkg::npr_lcw_s np_out_reg;
  npr_pkg::npr_lcw_s np_in_reg;
  logic [npr_pkg::EVT_N-1:0] irq_mask_reg;
  logic [npr_pkg::EVT_N-1:0] irq_sts;
  logic [npr_pkg::EVT_N-1:0] irq_set;
  logic [npr_pkg::EVT_N-1:0] irq_clr;
  logic page_flag;
  logic page_flag_clr;
  logic irq_reg;
  logic aw_full;
  logic w_full;
  logic [31:0] aw_addr;
  logic [35:0] w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic [7:0] wr_idx;
  logic wr_hit;
  logic wr_aligned;
  logic [15:0] wr_bytemask;
  logic [15:0] np_out_wr;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic rd_go;
  logic [7:0] rd_idx;
  logic [31:0] rd_data;
  logic rd_hit;

  // Address and data are held apart so they may arrive in either order
  npr_chan_hold #(
    .W(32)
  ) u_aw_hold (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RST_N_I),
    .valid_i(S_AXI_AWVALID_I),
    .data_i(S_AXI_AWADDR_I),
    .take_i(wr_go),
    .ready_o(S_AXI_AWREADY_O),
    .full_o(aw_full),
    .data_o(aw_addr)
  );

  npr_chan_hold #(
    .W(36)
  ) u_w_hold (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RST_N_I),
    .valid_i(S_AXI_WVALID_I),
    .data_i({S_AXI_WSTRB_I, S_AXI_WDATA_I}),
    .take_i(wr_go),
    .ready_o(S_AXI_WREADY_O),
    .full_o(w_full),
    .data_o(w_held)
  );

  assign w_data = w_held[31:0];
  assign w_strb = w_held[35:32];

  // A write completes only once the previous answer was collected
  assign wr_go = aw_full & w_full & ~bvalid_reg;
  assign wr_idx = aw_addr[9:2];
  assign wr_aligned = (aw_addr[1:0] == 2'h0) && (aw_addr[31:10] == 22'h0);
  assign wr_bytemask = {{8{w_strb[1]}}, {8{w_strb[0]}}};

  // Decode of the held write address
  always_comb begin
    wr_hit = 1'b0;
    if (wr_aligned) begin
      unique case (wr_idx)
        npr_pkg::IDX_NEXT_PAGE_OUT,
        npr_pkg::IDX_NEXT_PAGE_IN,
        npr_pkg::IDX_PAGE_STATUS,
        npr_pkg::IDX_IRQ_STATUS,
        npr_pkg::IDX_IRQ_MASK: begin
          wr_hit = 1'b1;
        end
        default: begin
          wr_hit = 1'b0;
        end
      endcase
    end
  end

  // writable bits merged
  // Only byte lanes that are strobed and bits that software owns change
  assign np_out_wr = (np_out_reg & ~(wr_bytemask & npr_pkg::NP_OUT_WMASK))
                   | (w_data[15:0] & wr_bytemask & npr_pkg::NP_OUT_WMASK);

  // Outgoing page register; read-only bits follow the engine
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      np_out_reg <= npr_pkg::NP_RESET;
    end else begin
      if (wr_go && wr_hit && (wr_idx == npr_pkg::IDX_NEXT_PAGE_OUT)) begin
        np_out_reg.more_pages_flag <= np_out_wr[npr_pkg::BIT_MORE];
        np_out_reg.message_page_flag <= np_out_wr[npr_pkg::BIT_MSG];
        np_out_reg.comply_acknowledge <= np_out_wr[npr_pkg::BIT_COMPLY];
        np_out_reg.code <= np_out_wr[10:0];
      end
      np_out_reg.ack <= LOCAL_ACK_I;
      if (LCW_TX_SENT_I) begin
        np_out_reg.alternation_bit <= ~np_out_reg.alternation_bit;
      end
    end
  end

  // Captured partner page
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      np_in_reg <= npr_pkg::NP_RESET;
    end else if (LCW_RX_VALID_I) begin
      np_in_reg <= LCW_RX_WORD_I;
    end
  end

  assign page_flag_clr = rd_go && (rd_idx == npr_pkg::IDX_PAGE_STATUS) && rd_hit;

  npr_sticky u_page_flag (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RST_N_I),
    .set_i(LCW_RX_VALID_I),
    .clr_i(page_flag_clr),
    .q_o(page_flag)
  );

  // Interrupt events: a page arrived, a page went out
  assign irq_set[npr_pkg::EVT_RX_PAGE] = LCW_RX_VALID_I;
  assign irq_set[npr_pkg::EVT_TX_PAGE] = LCW_TX_SENT_I;
  assign irq_clr = (wr_go && wr_hit && (wr_idx == npr_pkg::IDX_IRQ_STATUS) && w_strb[0])
                 ? w_data[npr_pkg::EVT_N-1:0] : '0;

  // One sticky cell per event, cleared by writing one
  genvar gi;
  generate
    for (gi = 0; gi < npr_pkg::EVT_N; gi++) begin : g_evt
      npr_sticky u_evt (
        .clk_i(CLK_SYS_I),
        .rst_n_i(RST_N_I),
        .set_i(irq_set[gi]),
        .clr_i(irq_clr[gi]),
        .q_o(irq_sts[gi])
      );
    end
  endgenerate

  // Mask register
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      irq_mask_reg <= npr_pkg::IRQ_MASK_RESET;
    end else if (wr_go && wr_hit && (wr_idx == npr_pkg::IDX_IRQ_MASK) && w_strb[0]) begin
      irq_mask_reg <= w_data[npr_pkg::EVT_N-1:0];
    end
  end

  // Interrupt level, registered so the pin is glitch free
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_sts & irq_mask_reg);
    end
  end

  // Write answer; unmapped or misaligned addresses get an error
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= npr_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_hit ? npr_pkg::RESP_OKAY : npr_pkg::RESP_SLVERR;
    end else if (bvalid_reg && S_AXI_BREADY_I) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read side: one read in flight, answer one edge after the address
  assign rd_go = S_AXI_ARVALID_I & arready_reg;
  assign rd_idx = S_AXI_ARADDR_I[9:2];

  // Read multiplexer; narrow registers sit in the low bits
  always_comb begin
    rd_data = 32'h0;
    rd_hit = (S_AXI_ARADDR_I[1:0] == 2'h0) && (S_AXI_ARADDR_I[31:10] == 22'h0);
    unique case (rd_idx)
      npr_pkg::IDX_NEXT_PAGE_OUT: begin
        rd_data[15:0] = np_out_reg;
      end
      npr_pkg::IDX_NEXT_PAGE_IN: begin
        rd_data[15:0] = np_in_reg;
      end
      npr_pkg::IDX_PAGE_STATUS: begin
        rd_data[0] = page_flag;
      end
      npr_pkg::IDX_IRQ_STATUS: begin
        rd_data[npr_pkg::EVT_N-1:0] = irq_sts;
      end
      npr_pkg::IDX_IRQ_MASK: begin
        rd_data[npr_pkg::EVT_N-1:0] = irq_mask_reg;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
    if (!rd_hit) begin
      rd_data = 32'h0;
    end
  end

  // Read handshake; ready drops while the answer waits
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= npr_pkg::RESP_OKAY;
    end else if (rd_go) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_data;
      rresp_reg <= rd_hit ? npr_pkg::RESP_OKAY : npr_pkg::RESP_SLVERR;
    end else if (rvalid_reg && S_AXI_RREADY_I) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end else if (!rvalid_reg) begin
      arready_reg <= 1'b1;
    end
  end

  assign S_AXI_BVALID_O = bvalid_reg;
  assign S_AXI_BRESP_O = bresp_reg;
  assign S_AXI_ARREADY_O = arready_reg;
  assign S_AXI_RVALID_O = rvalid_reg;
  assign S_AXI_RDATA_O = rdata_reg;
  assign S_AXI_RRESP_O = rresp_reg;
  assign NP_TX_WORD_O = np_out_reg;
  assign PAGE_RX_FLAG_O = page_flag;
  assign IRQ_O = irq_reg;

endmodule

// ---- npr_chk.sv ----
/*
  Assertion checker for the next page register bank.
  Assumes it is bound to npr_top and sees only its ports.
*/
`timescale 1ns/10ps
module npr_chk (
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [1:0] S_AXI_BRESP_O,
  input wire logic LCW_RX_VALID_I,
  input wire logic LCW_TX_SENT_I,
  input wire logic LOCAL_ACK_I,
  input wire npr_pkg::npr_lcw_s NP_TX_WORD_O,
  input wire logic PAGE_RX_FLAG_O
);
  // One clock domain, so one clocking and one reset for all
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);

  // Outgoing page checks
  property p_rst_val;
    $rose(RST_N_I) |-> NP_TX_WORD_O == npr_pkg::NP_RESET;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("page reset value");
  property p_ack;
    $past(RST_N_I) |-> NP_TX_WORD_O.ack == $past(LOCAL_ACK_I);
  endproperty
  a_ack: assert property (p_ack) else $error("ack bit lag");
  property p_alt_flip;
    LCW_TX_SENT_I |=> NP_TX_WORD_O.alternation_bit != $past(NP_TX_WORD_O.alternation_bit);
  endproperty
  a_alt_flip: assert property (p_alt_flip) else $error("toggle missed");
  property p_alt_hold;
    !LCW_TX_SENT_I |=> $stable(NP_TX_WORD_O.alternation_bit);
  endproperty
  a_alt_hold: assert property (p_alt_hold) else $error("toggle moved");

  // Page received flag: sets on a word, holds until a read
  property p_flag_set;
    LCW_RX_VALID_I |=> PAGE_RX_FLAG_O;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");
  property p_flag_hold;
    PAGE_RX_FLAG_O && !(S_AXI_ARVALID_I && S_AXI_ARREADY_O) |=> PAGE_RX_FLAG_O;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");

  // Answers stand until taken
  property p_r_hold;
    S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_b_hold;
    S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
endmodule

bind npr_top npr_chk u_npr_chk (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I),
  .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
  .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
  .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
  .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_BRESP_O(S_AXI_BRESP_O),
  .LCW_RX_VALID_I(LCW_RX_VALID_I), .LCW_TX_SENT_I(LCW_TX_SENT_I),
  .LOCAL_ACK_I(LOCAL_ACK_I), .NP_TX_WORD_O(NP_TX_WORD_O), .PAGE_RX_FLAG_O(PAGE_RX_FLAG_O));

// ---- npr_partner.sv ----
/*
  Link partner model seen through the arbitration engine pulses.
  Assumes the bench clock; tasks change outputs just after an edge.
*/
`timescale 1ns/10ps
module npr_partner (
  input wire logic clk_i,
  output logic rx_valid_o,
  output npr_pkg::npr_lcw_s rx_word_o,
  output logic tx_sent_o,
  output logic ack_o
);
  // Quiet at time zero
  initial begin
    rx_valid_o = 1'b0;
    rx_word_o = 16'h5a3c;
    tx_sent_o = 1'b0;
    ack_o = 1'b0;
  end
  // One accepted partner word; calls may follow back to back
  task automatic rx(input logic [15:0] w);
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_word_o <= w;
  endtask
  task automatic tx();
    @(posedge clk_i);
    tx_sent_o <= 1'b1;
  endtask
  // Released word bus shows the inverse so a stale value cannot pass
  task automatic idle();
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    tx_sent_o <= 1'b0;
    rx_word_o <= ~rx_word_o;
  endtask
  task automatic set_ack(input logic b);
    @(posedge clk_i);
    ack_o <= b;
  endtask
endmodule

// ---- testbench.sv ----
/*
  Self-checking bench for the next page register bank.
  Assumes npr_top, the partner model and the bound checker.
*/
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, rdata, d;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic [3:0] ws = 4'hf;
  logic awr, wrdy, bv, arr, rv, irq, flag, rxv, txs, lack;
  logic [1:0] bresp, rresp, r;
  npr_pkg::npr_lcw_s rxw, txw;
  int fails = 0;
  int checks = 0;

  npr_top u_npr_top (.CLK_SYS_I(clk), .RST_N_I(rst_n), .S_AXI_AWADDR_I(awa),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(ws),
    .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
    .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rready), .LCW_RX_VALID_I(rxv), .LCW_RX_WORD_I(rxw),
    .LCW_TX_SENT_I(txs), .LOCAL_ACK_I(lack), .NP_TX_WORD_O(txw), .PAGE_RX_FLAG_O(flag),
    .IRQ_O(irq));
  npr_partner u_npr_partner (.clk_i(clk), .rx_valid_o(rxv), .rx_word_o(rxw),
    .tx_sent_o(txs), .ack_o(lack));

  initial begin
    forever #20 clk = ~clk;
  end

  // Write: address and data offered together, ready for the answer only once it shows
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    forever begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
      if (bready && bv) break;
      if (bv) bready <= 1'b1;
    end
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    forever begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rready && rv) break;
      if (rv) rready <= 1'b1;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(32'h1c); chk("out", 32'h2001, d);
    rd(32'h20); chk("in", 32'h2001, d);
    for (int i = 0; i < 3; i++) begin
      rd(32'h40 + 4 * i); chk("evt", 32'h0, d);
    end
    wr(32'h1c, 32'hffff); rd(32'h1c); chk("out", 32'hb7ff, d);
    // Low lane only: the upper byte must keep its flags
    ws <= 4'h1;
    wr(32'h1c, 32'h0); rd(32'h1c); chk("out", 32'hb700, d);
    ws <= 4'hf;
    wr(32'h1c, 32'h0); rd(32'h1c); chk("out", 32'h0, d);
    u_npr_partner.set_ack(1'b1);
    rd(32'h1c); chk("out", 32'h4000, d);
    u_npr_partner.set_ack(1'b0);
    u_npr_partner.tx();
    u_npr_partner.idle();
    rd(32'h1c); chk("out", 32'h0800, d);
    chk("irq", 32'h0, irq);
    wr(32'h48, 32'h1);
    u_npr_partner.rx(16'h0a5a);
    u_npr_partner.idle();
    rd(32'h20); chk("in", 32'h0a5a, d);
    // Back to back words: only the last stands, whole
    u_npr_partner.rx(16'h1234);
    u_npr_partner.rx(16'hf5a5);
    u_npr_partner.idle();
    rd(32'h20); chk("in", 32'hf5a5, d);
    chk("irq", 32'h1, irq);
    rd(32'h40); chk("stat", 32'h1, d);
    rd(32'h40); chk("stat", 32'h0, d);
    rd(32'h44); chk("irq_stat", 32'h3, d);
    wr(32'h44, 32'h1); rd(32'h44); chk("irq_stat", 32'h2, d);
    chk("irq", 32'h0, irq);
    wr(32'h20, 32'h0); rd(32'h20); chk("in", 32'hf5a5, d);
    rd(32'h100); chk("rresp", 32'h2, r);
    chk("rdata", 32'h0, d);
    wr(32'h104, 32'h1); chk("bresp", 32'h2, r);
    print_verdict();
  end

  // Watchdog far beyond the hundred-odd cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    print_verdict();
  end
endmodule
